// file: hdl/ocg_cfg.svh
// Register map, field positions, reset values and timing counts of the output stage
`ifndef OCG_CFG_SVH
`define OCG_CFG_SVH
`define OCG_NREG       88
`define OCG_A_DIV0     8'h08
`define OCG_A_DIV1     8'h09
`define OCG_B_DIV0     8'h0a
`define OCG_B_DIV1     8'h0b
`define OCG_C_DIV      8'h0c
`define OCG_D_DIV      8'h0d
`define OCG_FS_HI      8'h0e
`define OCG_MISC       8'h0f
`define OCG_L2_BASE    8'h11
`define OCG_L3_BASE    8'h14
`define OCG_CAP        8'h18
`define OCG_OSUSP      8'h19
`define OCG_LSUSP      8'h1a
`define OCG_ODIS       8'h1b
`define OCG_L1_BASE    8'h40
`define OCG_LAST_LO    8'h1b
`define OCG_LAST_HI    8'h57
`define OCG_FS0_BIT    7
`define OCG_PDN_BIT    3
`define OCG_XBUF_BIT   2
`define OCG_PO_BIT     2
`define OCG_LF_LSB     3
`define OCG_EN_BIT     6
`define OCG_BANK_BIT   7
`define OCG_SUSPEN_BIT 7
`define OCG_REG_RST    8'h00
`define OCG_LATCH_CYC  4'h4
`endif

// file: hdl/ocg_pkg.sv
// Shared types of the output divider and crosspoint block
package ocg_pkg;
  `include "ocg_cfg.svh"

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_DEV  = 2'b01,
    SER_REG  = 2'b10,
    SER_DATA = 2'b11
  } ocg_ser_st_t;

  typedef struct packed {
    logic       src_d;
    logic [6:0] cnt;
    logic       clk;
  } ocg_div_t;

  typedef struct packed {
    logic                          scl_d;
    logic                          sda_d;
    ocg_ser_st_t                   st;
    logic [3:0]                    bitc;
    logic [7:0]                    sh;
    logic [7:0]                    ptr;
    logic                          ack;
    logic                          wr;
    logic [`OCG_NREG-1:0][7:0]     regs;
    logic [3:0]                    lcnt;
    logic [1:0]                    fs_lat;
    logic [5:0]                    oe;
    logic                          refb;
    logic                          valid;
  } ocg_top_t;
endpackage : ocg_pkg

// file: hdl/ocg_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module ocg_sync #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // Raw and synchronised levels
  input  wire logic [W-1:0] d_i,
  output wire logic [W-1:0] q_o
);
  logic [1:0][W-1:0] s_ff;
  logic [1:0][W-1:0] nxt_s;

  always_comb begin
    nxt_s = {s_ff[0], d_i};
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_o = s_ff[1];
endmodule : ocg_sync

// file: hdl/ocg_div7.sv
// Seven-bit divider counting source half periods
`timescale 1ns/1ps
module ocg_div7
  import ocg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Source level and setting
  input  wire logic       src_i,
  input  wire logic [6:0] div_i,
  input  wire logic       run_i,
  // Divided clock
  output wire logic       clk_o
);
  ocg_div_t d_ff;
  ocg_div_t nxt_d;
  logic     edge_c;

  assign edge_c = src_i ^ d_ff.src_d;
  assign clk_o  = d_ff.clk;

  always_comb begin
    nxt_d       = d_ff;
    nxt_d.src_d = src_i;
    if (!run_i || div_i == 7'h00) begin
      nxt_d.cnt = 7'h00;
      nxt_d.clk = 1'b0;
    end else if (edge_c) begin
      if (d_ff.cnt >= div_i - 7'h01) begin
        nxt_d.cnt = 7'h00;
        nxt_d.clk = ~d_ff.clk;
      end else begin
        nxt_d.cnt = d_ff.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      d_ff <= '0;
    end else begin
      d_ff <= nxt_d;
    end
  end

  a_div_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!run_i || div_i == 7'h00) |=> !clk_o) else $error("stopped divider still toggles");
  a_div_edge: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (run_i && !edge_c) |=> $stable(clk_o)) else $error("divider moved without source edge");
endmodule : ocg_div7

// file: hdl/ocg_top.sv
// Output crosspoint, dividers, power gating and serial register file
`timescale 1ns/1ps
`include "ocg_cfg.svh"
module ocg_top
  import ocg_pkg::*;
#(
  // Serial device address, value arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h35
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Serial pins, levels also latched as frequency selects
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output wire logic        sda_o,
  output wire logic        sda_oe_o,
  // Power and frequency select pins
  input  wire logic        pd_gate_n_i,
  input  wire logic        freq_sel_lp_n_i,
  // Clock sources and loop lock
  input  wire logic        ref_clk_i,
  input  wire logic [2:0]  loop_clk_i,
  input  wire logic [2:0]  loop_lock_i,
  // Loop and oscillator controls
  output wire logic [2:0]  loop_run_o,
  output wire logic [23:0] loop_q_o,
  output wire logic [29:0] loop_p_o,
  output wire logic [2:0]  loop_po_o,
  output wire logic [8:0]  loop_lf_o,
  output wire logic        osc_run_o,
  output wire logic [5:0]  osc_cap_o,
  output wire logic        divider_bank_select_o,
  output wire logic        clocks_valid_o,
  // Clock outputs a to e and reference buffer
  output wire logic [4:0]  out_clk_o,
  output wire logic [4:0]  out_oe_o,
  output wire logic        ref_buf_o,
  output wire logic        ref_buf_oe_o
);
  localparam int NO = 5;

  ocg_top_t            t_ff;
  ocg_top_t            nxt_t;
  logic [10:0]         pin_s;
  logic [2:0]          fs_idx;
  logic [7:0]          l1_a;
  logic [2:0][7:0]     lq;
  logic [2:0][7:0]     lp;
  logic [2:0][7:0]     lc;
  logic [2:0][9:0]     lpf;
  logic [2:0]          loop_en;
  logic [2:0]          loop_run;
  logic [2:0]          lf_v;
  logic [2:0][2:0]     lf_a;
  logic                bank;
  logic                shutdown;
  logic                suspend;
  logic                out_gate;
  logic [3:0][7:0]     dreg;
  logic [3:0][2:0]     fs_code;
  logic [NO-1:0][6:0]  div_val;
  logic [NO-1:0]       src;
  logic [NO-1:0]       run;
  logic [7:0]          misc;
  logic [7:0]          odis;
  logic [7:0]          omask;
  logic [7:0]          lmask;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_c;
  logic                stop_c;

  function automatic logic reg_hit(input logic [7:0] a);
    return (a >= `OCG_A_DIV0 && a <= `OCG_LAST_LO) || (a >= `OCG_L1_BASE && a <= `OCG_LAST_HI);
  endfunction : reg_hit

  // Code 001 is reserved and yields a quiet source
  function automatic logic src_lvl(input logic [2:0] code, input logic [3:0] s);
    return (code == 3'b001) ? 1'b0 : s[code[2:1]] ^ (code[0] & (|code[2:1]));
  endfunction : src_lvl

  function automatic logic src_up(input logic [2:0] code, input logic [2:0] lrun, input logic sd);
    case (code[2:1])
      2'b00:   return !code[0] && !sd;
      2'b01:   return lrun[0];
      2'b10:   return lrun[1];
      default: return lrun[2];
    endcase
  endfunction : src_up

  // Pin order: ref, loops, gate, select, lock, scl, sda
  ocg_sync #(
    .W (11)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({sda_i, scl_i, loop_lock_i, freq_sel_lp_n_i, pd_gate_n_i, loop_clk_i, ref_clk_i}),
    .q_o     (pin_s)
  );

  assign scl_rise = pin_s[9] & ~t_ff.scl_d;
  assign scl_fall = ~pin_s[9] & t_ff.scl_d;
  assign start_c  = t_ff.scl_d & pin_s[9] & t_ff.sda_d & ~pin_s[10];
  assign stop_c   = t_ff.scl_d & pin_s[9] & ~t_ff.sda_d & pin_s[10];

  assign misc  = t_ff.regs[`OCG_MISC];
  assign odis  = t_ff.regs[`OCG_ODIS];
  assign omask = t_ff.regs[`OCG_OSUSP];
  assign lmask = t_ff.regs[`OCG_LSUSP];

  always_comb begin
    fs_idx = {pin_s[5], t_ff.fs_lat};
    l1_a   = `OCG_L1_BASE + {4'h0, fs_idx, 1'b0} + {5'h0, fs_idx};
    lq[0]  = t_ff.regs[l1_a[6:0]];
    lp[0]  = t_ff.regs[l1_a[6:0] + 7'h01];
    lc[0]  = t_ff.regs[l1_a[6:0] + 7'h02];
    lq[1]  = t_ff.regs[`OCG_L2_BASE];
    lp[1]  = t_ff.regs[`OCG_L2_BASE + 8'h01];
    lc[1]  = t_ff.regs[`OCG_L2_BASE + 8'h02];
    lq[2]  = t_ff.regs[`OCG_L3_BASE];
    lp[2]  = t_ff.regs[`OCG_L3_BASE + 8'h01];
    lc[2]  = t_ff.regs[`OCG_L3_BASE + 8'h02];
    bank   = lc[0][`OCG_BANK_BIT];
    out_gate = ~pin_s[4];
    shutdown = misc[`OCG_PDN_BIT] & ~pin_s[4];
    suspend  = lmask[`OCG_SUSPEN_BIT] & ~pin_s[5];
    for (int k = 0; k < 3; k++) begin
      lpf[k]     = {lc[k][1:0], lp[k]};
      lf_v[k]    = lc[k][`OCG_PO_BIT];
      lf_a[k]    = lc[k][`OCG_LF_LSB +: 3];
      loop_en[k] = lc[k][`OCG_EN_BIT];
      loop_run[k] = loop_en[k] & ~shutdown & ~(suspend & lmask[k]);
    end
    // bank select for A and B
    dreg[0] = bank ? t_ff.regs[`OCG_A_DIV1] : t_ff.regs[`OCG_A_DIV0];
    dreg[1] = bank ? t_ff.regs[`OCG_B_DIV1] : t_ff.regs[`OCG_B_DIV0];
    // single register for C and D
    dreg[2] = t_ff.regs[`OCG_C_DIV];
    dreg[3] = t_ff.regs[`OCG_D_DIV];
    for (int i = 0; i < 4; i++) begin
      fs_code[i] = {t_ff.regs[`OCG_FS_HI][2*i +: 2], dreg[i][`OCG_FS0_BIT]};
      div_val[i] = dreg[i][6:0];
      src[i]     = src_lvl(fs_code[i], pin_s[3:0]);
      run[i]     = (div_val[i] != 7'h00) & ~odis[i] & src_up(fs_code[i], loop_run, shutdown);
    end
    case (misc[1:0])
      2'b01:   div_val[4] = 7'h04;
      2'b10:   div_val[4] = 7'h02;
      2'b11:   div_val[4] = 7'h03;
      default: div_val[4] = 7'h00;
    endcase
    src[4] = pin_s[1];
    run[4] = (div_val[4] != 7'h00) & ~odis[4] & loop_run[0];
  end

  always_comb begin
    nxt_t       = t_ff;
    nxt_t.scl_d = pin_s[9];
    nxt_t.sda_d = pin_s[10];
    nxt_t.wr    = 1'b0;
    nxt_t.refb  = pin_s[0] & ~shutdown;
    nxt_t.valid = &(pin_s[8:6] | ~loop_run);
    for (int i = 0; i < NO; i++) begin
      nxt_t.oe[i] = run[i] & ~out_gate & ~(suspend & omask[i]);
    end
    nxt_t.oe[5] = misc[`OCG_XBUF_BIT] & ~shutdown & ~out_gate & ~(suspend & omask[5]) & ~odis[5];
    if (t_ff.lcnt != `OCG_LATCH_CYC) begin
      nxt_t.lcnt   = t_ff.lcnt + 4'h1;
      nxt_t.fs_lat = {pin_s[9], pin_s[10]};
    end
    // serial port never gated by pins
    if (start_c) begin
      nxt_t.st   = SER_DEV;
      nxt_t.bitc = 4'h0;
      nxt_t.ack  = 1'b0;
    end else if (stop_c) begin
      nxt_t.st  = SER_IDLE;
      nxt_t.ack = 1'b0;
    end else if (scl_fall && t_ff.ack) begin
      nxt_t.ack = 1'b0;
    end else if (scl_rise && !t_ff.ack && t_ff.st != SER_IDLE) begin
      nxt_t.sh   = {t_ff.sh[6:0], pin_s[10]};
      nxt_t.bitc = t_ff.bitc + 4'h1;
    end else if (scl_fall && t_ff.bitc == 4'h8) begin
      nxt_t.bitc = 4'h0;
      nxt_t.ack  = 1'b1;
      case (t_ff.st)
        SER_DEV: begin
          if (t_ff.sh != {DEV_ADDR, 1'b0}) begin
            nxt_t.st  = SER_IDLE;
            nxt_t.ack = 1'b0;
          end else begin
            nxt_t.st = SER_REG;
          end
        end
        SER_REG: begin
          nxt_t.ptr = t_ff.sh;
          nxt_t.st  = SER_DATA;
        end
        SER_DATA: begin
          nxt_t.wr  = 1'b1;
          nxt_t.ptr = t_ff.ptr + 8'h01;
          if (reg_hit(t_ff.ptr)) begin
            nxt_t.regs[t_ff.ptr[6:0]] = t_ff.sh;
          end
        end
        default: begin
          nxt_t.st  = SER_IDLE;
          nxt_t.ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      t_ff <= '0;
      for (int r = 0; r < `OCG_NREG; r++) begin
        t_ff.regs[r] <= `OCG_REG_RST;
      end
    end else begin
      t_ff <= nxt_t;
    end
  end

  for (genvar g = 0; g < NO; g++) begin : g_div
    ocg_div7 u_div (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .src_i   (src[g]),
      .div_i   (div_val[g]),
      .run_i   (run[g]),
      .clk_o   (out_clk_o[g])
    );
  end

  // Open-drain data line only ever pulls low
  assign sda_o                 = 1'b0;
  assign sda_oe_o              = t_ff.ack;
  assign loop_run_o            = loop_run;
  assign loop_q_o              = lq;
  assign loop_p_o              = lpf;
  assign loop_po_o             = lf_v;
  assign loop_lf_o             = lf_a;
  assign osc_run_o             = ~shutdown;
  assign osc_cap_o             = t_ff.regs[`OCG_CAP][5:0];
  assign divider_bank_select_o = bank;
  assign clocks_valid_o        = t_ff.valid;
  assign out_oe_o              = t_ff.oe[4:0];
  assign ref_buf_o             = t_ff.refb;
  assign ref_buf_oe_o          = t_ff.oe[5];

  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_gate_tristate: assert property (
    !pin_s[4] |=> (out_oe_o == 5'h00) && !ref_buf_oe_o) else $error("outputs driven with gate low");
  a_shdn_loops: assert property (
    (misc[`OCG_PDN_BIT] && !pin_s[4]) |-> (loop_run_o == 3'h0) && !osc_run_o) else $error("shutdown left loops on");
  a_zero_div: assert property (
    (t_ff.regs[`OCG_C_DIV][6:0] == 7'h00) |=> !out_oe_o[2]) else $error("zero divider still drives");
  a_e_off: assert property (
    (misc[1:0] == 2'b00) |=> !out_oe_o[4] ##1 !out_clk_o[4]) else $error("output e active when off");
  a_loop1_dep: assert property (
    !loop_run[0] |=> !out_oe_o[4]) else $error("loop one dependant kept running");
  a_out_disable: assert property (
    odis[0] |=> !out_oe_o[0]) else $error("disabled output a driven");
  a_susp_out: assert property (
    (suspend && omask[1]) |=> !out_oe_o[1]) else $error("suspended output b driven");
  a_ack_commit: assert property (
    (scl_fall && !t_ff.ack && t_ff.st == SER_DATA && t_ff.bitc == 4'h8 && reg_hit(t_ff.ptr))
      |=> (t_ff.regs[$past(t_ff.ptr[6:0])] == $past(t_ff.sh)) && sda_oe_o) else $error("byte not live at ack");
  a_fs_hold: assert property (
    (t_ff.lcnt == `OCG_LATCH_CYC) |=> $stable(t_ff.fs_lat)) else $error("select latch moved after start-up");

  // Source routing, phase and divider selection
  a_src_ref: assert property (
    (fs_code[2] == 3'b000) |-> (src[2] == pin_s[0])) else $error("code zero not routed from reference");
  a_neg_phase: assert property (
    (fs_code[3] == 3'b011) |-> (src[3] == ~pin_s[1])) else $error("negative loop one phase not inverted");
  a_run_nonzero: assert property (
    run[0] |-> (div_val[0] != 7'h00)) else $error("output a runs with zero divider");
  a_cd_single: assert property (
    div_val[3] == t_ff.regs[`OCG_D_DIV][6:0]) else $error("output d divider not from its register");
  a_e_quarter: assert property (
    (misc[1:0] == 2'b01) |-> (div_val[4] == 7'h04)) else $error("output e code one not divide by four");
  a_e_third: assert property (
    (misc[1:0] == 2'b11) |-> (div_val[4] == 7'h03)) else $error("output e code three not divide by three");
  a_ref_copy: assert property (
    !shutdown |=> (ref_buf_o == $past(pin_s[0]))) else $error("reference buffer not following reference");
  // Power gating, loop control, serial port and bank select
  a_osc_on: assert property (
    !misc[`OCG_PDN_BIT] |-> osc_run_o) else $error("oscillator stopped with shutdown function off");
  a_susp_loop: assert property (
    (suspend && lmask[2]) |-> !loop_run_o[2]) else $error("suspended loop three still running");
  a_susp_gate: assert property (
    !lmask[`OCG_SUSPEN_BIT] |-> !suspend) else $error("suspend active while not enabled");
  a_loop_en: assert property (
    !loop_en[1] |-> !loop_run_o[1]) else $error("disabled loop two still running");
  a_valid_lock: assert property (
    ((loop_run & ~pin_s[8:6]) != 3'h0) |=> !clocks_valid_o) else $error("valid with running loop unlocked");
  a_ser_live: assert property (
    start_c |=> (t_ff.st == SER_DEV)) else $error("serial start not taken");
  a_ptr_inc: assert property (
    t_ff.wr |-> (t_ff.ptr == $past(t_ff.ptr) + 8'h01)) else $error("pointer not advanced after data byte");
  a_bank_src: assert property (
    bank |-> (div_val[1] == t_ff.regs[`OCG_B_DIV1][6:0])) else $error("output b not using selected bank");
endmodule : ocg_top

// file: verif/ocg_host.sv
// Behavioural two-wire programming host driving the serial pins
`timescale 1ns/1ps
module ocg_host (
  // Clock and device acknowledge
  input  wire logic mclk_i,
  input  wire logic sda_oe_i,
  // Host pin levels, data high means released
  output logic      scl_o,
  output logic      sda_o
);
  localparam int PH = 8;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : gap

  task automatic start();
    gap(PH);
    sda_o = 1'b0;
    gap(PH);
    scl_o = 1'b0;
  endtask : start

  // Data only moves well after the clock fall, so no false start or stop
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int k = 7; k >= 0; k--) begin
      gap(2);
      sda_o = b[k];
      gap(PH);
      scl_o = 1'b1;
      gap(PH);
      scl_o = 1'b0;
    end
    gap(2);
    sda_o = 1'b1;
    gap(PH);
    ack = sda_oe_i;
    scl_o = 1'b1;
    gap(PH);
    scl_o = 1'b0;
  endtask : xfer

  task automatic stop();
    gap(2);
    sda_o = 1'b0;
    gap(PH);
    scl_o = 1'b1;
    gap(PH);
    sda_o = 1'b1;
    gap(PH);
  endtask : stop
endmodule : ocg_host

// file: verif/tb_top.sv
// Self-checking bench of the output divider and crosspoint block
`timescale 1ns/1ps
module tb_top;
  import ocg_pkg::*;
  localparam logic [6:0] DEV = 7'h35;
  logic             mclk_i, rst_n_i, pd_gate_n_i, freq_sel_lp_n_i, ref_clk_i;
  logic [2:0]       loop_clk_i, loop_lock_i;
  wire logic        scl_w, sda_h, sda_pin, sda_oe_o, osc_run_o, dbs_o, valid_o, ref_buf_o, ref_buf_oe_o;
  wire logic [2:0]  loop_run_o, loop_po_o;
  wire logic [23:0] loop_q_o;
  wire logic [29:0] loop_p_o;
  wire logic [8:0]  loop_lf_o;
  wire logic [5:0]  osc_cap_o, obs;
  wire logic [4:0]  out_clk_o, out_oe_o;
  wire logic        sda_lvl;
  int               errors, checked, hi, per;
  logic             ak;
  logic [7:0]       q, p;

  // Data line has a pull-up
  assign sda_lvl = sda_h & ~sda_oe_o;
  assign obs = {ref_buf_o, out_clk_o};

  ocg_host u_ocg_host (.mclk_i(mclk_i), .sda_oe_i(sda_oe_o), .scl_o(scl_w), .sda_o(sda_h));

  ocg_top #(.DEV_ADDR(DEV)) u_ocg_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_w), .sda_i(sda_lvl),
    .sda_o(sda_pin), .sda_oe_o(sda_oe_o), .pd_gate_n_i(pd_gate_n_i), .freq_sel_lp_n_i(freq_sel_lp_n_i),
    .ref_clk_i(ref_clk_i), .loop_clk_i(loop_clk_i), .loop_lock_i(loop_lock_i), .loop_run_o(loop_run_o),
    .loop_q_o(loop_q_o), .loop_p_o(loop_p_o), .loop_po_o(loop_po_o), .loop_lf_o(loop_lf_o),
    .osc_run_o(osc_run_o), .osc_cap_o(osc_cap_o), .divider_bank_select_o(dbs_o), .clocks_valid_o(valid_o),
    .out_clk_o(out_clk_o), .out_oe_o(out_oe_o), .ref_buf_o(ref_buf_o), .ref_buf_oe_o(ref_buf_oe_o));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Reference half period 5, loop half periods 4, 6 and 7 cycles
  initial begin
    ref_clk_i = 1'b0;
    forever begin
      repeat (5) @(posedge mclk_i);
      #1 ref_clk_i = ~ref_clk_i;
    end
  end
  for (genvar g = 0; g < 3; g++) begin : g_src
    initial begin
      loop_clk_i[g] = 1'b0;
      forever begin
        repeat (g == 0 ? 4 : g == 1 ? 6 : 7) @(posedge mclk_i);
        #1 loop_clk_i[g] = ~loop_clk_i[g];
      end
    end
  end

  function automatic int half(input logic [2:0] c);
    return c == 3'd0 ? 5 : c == 3'd1 ? 0 : c[2:1] == 2'd1 ? 4 : c[2:1] == 2'd2 ? 6 : 7;
  endfunction : half

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic wt(input int i, input logic lv, inout int n, inout int c);
    while (obs[i] !== lv && n < 6000) begin
      cyc(1);
      n++;
      c++;
    end
  endtask : wt

  // Skips two periods so that a change of divider has settled
  task automatic meas(input int i);
    int n;
    int d;
    n = 0;
    d = 0;
    hi = 0;
    for (int k = 0; k < 2; k++) begin
      wt(i, 1'b1, n, d);
      wt(i, 1'b0, n, d);
    end
    wt(i, 1'b1, n, d);
    wt(i, 1'b0, n, hi);
    per = hi;
    wt(i, 1'b1, n, per);
    if (n >= 6000) per = 0;
  endtask : meas

  task automatic chkclk(input string nm, input int i, input int n, input int h);
    meas(i);
    chk({nm, "_per"}, per, 2 * h * n);
    chk({nm, "_high"}, hi, h * n);
  endtask : chkclk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ocg_host.start();
    u_ocg_host.xfer({DEV, 1'b0}, ak);
    chk("ack_dev", ak, 1'b1);
    u_ocg_host.xfer(a, ak);
    chk("ack_reg", ak, 1'b1);
    u_ocg_host.xfer(d, ak);
    chk("ack_data", ak, 1'b1);
    u_ocg_host.stop();
    cyc(2);
  endtask : wr

  task automatic end_of_test();
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (90000) @(posedge mclk_i);
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    checked = 0;
    rst_n_i = 1'b0;
    pd_gate_n_i = 1'b1;
    freq_sel_lp_n_i = 1'b1;
    loop_lock_i = 3'h0;
    void'($urandom(32'hff99));
    repeat (6) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    cyc(8);
    chk("oe_rst", out_oe_o, 5'h0);
    chk("osc_rst", osc_run_o, 1'b1);
    // Output C on the reference, corner and random divide values
    for (int k = 0; k < 4; k++) begin
      q = k == 0 ? 8'd1 : k == 1 ? 8'd127 : 8'($urandom % 7 + 1);
      wr(8'h0c, q);
      chkclk("c_div", 2, q, 5);
    end
    wr(8'h57, 8'h40);
    wr(8'h13, 8'h40);
    wr(8'h16, 8'h40);
    // Every source code through output D
    for (int c = 0; c < 8; c++) begin
      wr(8'h0e, {c[2:1], 6'h0});
      wr(8'h0d, {c[0], 7'd3});
      chkclk("d_src", 3, 3, half(c[2:0]));
    end
    // Inactive bank written first, then selected
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h05);
    chkclk("a_bank0", 0, 2, 5);
    wr(8'h57, 8'hc0);
    chk("bank", dbs_o, 1'b1);
    chkclk("a_bank1", 0, 5, 5);
    freq_sel_lp_n_i = 1'b0;
    cyc(4);
    chk("bank_row3", dbs_o, 1'b0);
    chkclk("a_row3", 0, 2, 5);
    freq_sel_lp_n_i = 1'b1;
    cyc(4);
    for (int c = 1; c < 4; c++) begin
      wr(8'h0f, 8'(c));
      meas(4);
      chk("e_per", per, 8 * (c == 1 ? 4 : c));
    end
    wr(8'h0f, 8'h00);
    chk("e_off", out_oe_o[4], 1'b0);
    wr(8'h0f, 8'h01);
    wr(8'h57, 8'h80);
    chk("e_l1off", out_oe_o[4], 1'b0);
    chk("l1_run", loop_run_o[0], 1'b0);
    wr(8'h57, 8'hc0);
    chk("e_l1on", out_oe_o[4], 1'b1);
    wr(8'h0c, 8'h00);
    chk("c_zero", out_oe_o[2], 1'b0);
    wr(8'h0c, 8'h03);
    wr(8'h1b, 8'h08);
    chk("d_dis", out_oe_o[3], 1'b0);
    wr(8'h1b, 8'h00);
    wr(8'h16, 8'h00);
    chk("l3_run", loop_run_o[2], 1'b0);
    chk("d_l3off", out_oe_o[3], 1'b0);
    wr(8'h16, 8'h40);
    // Suspend set holds C and D, D being fed by loop three
    wr(8'h19, 8'h0c);
    wr(8'h1a, 8'h84);
    freq_sel_lp_n_i = 1'b0;
    cyc(4);
    chk("susp_run", loop_run_o[2:1], 2'b01);
    chk("susp_oe", out_oe_o[3:0], 4'b0001);
    freq_sel_lp_n_i = 1'b1;
    cyc(4);
    chk("wake_oe", out_oe_o[3:0], 4'b1101);
    wr(8'h1a, 8'h00);
    q = 8'($urandom % 64);
    wr(8'h18, q);
    chk("cap", osc_cap_o, q);
    wr(8'h30, 8'hff);
    chk("cap_unmapped", osc_cap_o, q);
    wr(8'h0f, 8'h04);
    chk("xbuf_oe", ref_buf_oe_o, 1'b1);
    chkclk("xbuf", 5, 1, 5);
    pd_gate_n_i = 1'b0;
    cyc(4);
    chk("gate_oe", {ref_buf_oe_o, out_oe_o}, 6'h0);
    chk("gate_osc", osc_run_o, 1'b1);
    wr(8'h0f, 8'h0c);
    chk("sd_osc", osc_run_o, 1'b0);
    chk("sd_run", loop_run_o, 3'h0);
    pd_gate_n_i = 1'b1;
    cyc(4);
    chk("wake_osc", osc_run_o, 1'b1);
    chk("wake_c", out_oe_o[2], 1'b1);
    loop_lock_i = 3'b011;
    cyc(5);
    chk("relock0", valid_o, 1'b0);
    loop_lock_i = 3'b111;
    cyc(5);
    chk("relock1", valid_o, 1'b1);
    // Loop two is stopped around the rewrite of its bytes
    wr(8'h13, 8'h00);
    q = 8'($urandom);
    p = 8'($urandom);
    u_ocg_host.start();
    u_ocg_host.xfer({DEV, 1'b0}, ak);
    u_ocg_host.xfer(8'h11, ak);
    u_ocg_host.xfer(q, ak);
    cyc(1);
    chk("q_at_ack", loop_q_o[15:8], q);
    chk("p_before", loop_p_o[17:10], 8'h00);
    u_ocg_host.xfer(p, ak);
    cyc(1);
    chk("p_at_ack", loop_p_o[17:10], p);
    u_ocg_host.stop();
    wr(8'h13, 8'h40);
    end_of_test();
  end
endmodule : tb_top
